//--- shared/hwt_pkg.sv
// Purpose: Shared constants and types for the hibernation wake timer.
// Assumes: Byte offsets on a 4-bit register address; 16-bit register data.
// Notes:   All figures used by the logic are named here once.

package hwt_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_PRELOAD = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h8;

    localparam logic [DATA_W-1:0] PRELOAD_RST = 16'h0000;
    localparam logic [DATA_W-1:0] CONTROL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] RDATA_NONE = 16'h0000;

    // Resolution select bit in the control register.
    localparam int CTRL_RES_BIT = 0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int SLOW_CLK_HZ = 32768;
    localparam int TICK_SHORT_NS = 30500;
    localparam int TICK_LONG_MS = 125;
    // Slow clock edges per long tick: 0.125 s of a 32.768 kHz clock.
    localparam int LONG_EDGES = (TICK_LONG_MS * SLOW_CLK_HZ) / 1000;
    localparam int PRE_W = $clog2(LONG_EDGES);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(LONG_EDGES - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = '0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hwt_bus_req_s;

    typedef enum logic [1:0] {
        CNT_IDLE = 2'b00,
        CNT_RUN = 2'b01,
        CNT_DONE = 2'b10
    } hwt_cnt_state_e;

endpackage

//--- rtl/hwt_tick_gen.sv
// Purpose: Slow clock synchroniser and tick prescaler.
// Assumes: slow_ref_clk is asynchronous to clk_sys and much slower.
// Notes:   tick is a one-cycle clk_sys pulse per counter step.

`timescale 1ns/1ps

module hwt_tick_gen (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic slow_ref_clk,
    input wire logic res_long,
    input wire logic restart,
    input wire logic run,
    output logic tick
);

    // ==========================================================
    // Synchroniser and edge detect
    // ==========================================================
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic slow_rise;
    logic [hwt_pkg::PRE_W-1:0] pre_r;
    logic tick_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= slow_ref_clk;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Prescaler and tick steps happen only on a detected slow clock rise, so tick timing follows the slow clock only.
    assign slow_rise = sync2_r & ~sync3_r;

    // ==========================================================
    // Prescaler
    // ==========================================================
    // A restart aligns the first step to a full tick after a new preload.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pre_r <= hwt_pkg::PRE_ZERO;
        end else if (restart) begin
            pre_r <= hwt_pkg::PRE_ZERO;
        end else if (run && slow_rise) begin
            if (pre_r == hwt_pkg::PRE_LAST) begin
                pre_r <= hwt_pkg::PRE_ZERO;
            end else begin
                pre_r <= pre_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tick_r <= 1'b0;
        end else begin
            // Short tick on each slow edge, long tick on each 4096th.
            tick_r <= run && !restart && slow_rise &&
                      (!res_long || pre_r == hwt_pkg::PRE_LAST);
        end
    end

    assign tick = tick_r;

endmodule // hwt_tick_gen

//--- rtl/hwt_wake_timer.sv
// Purpose: Sixteen-bit down-counting hibernation wake timer with register access.
// Assumes: resetn is the main-well reset; bus and power unit share clk_sys.
// Notes:   Reads answer one cycle after the request; writes finish in their cycle.

`timescale 1ns/1ps

module hwt_wake_timer (
    input wire logic clk_sys,
    input wire logic resetn,
    input hwt_pkg::hwt_bus_req_s bus_req,
    output logic [hwt_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic slow_ref_clk,
    input wire logic lp_req,
    output logic lp_ack,
    input wire logic sleep_en,
    output logic clk_req,
    output logic wake_event_out
);

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Address match used by the write decode only; reads decode the address in read_mux.
    function automatic logic addr_hit(
        input hwt_pkg::hwt_bus_req_s req,
        input logic [hwt_pkg::ADDR_W-1:0] ofs
    );
        addr_hit = req.sel && (req.addr == ofs);
    endfunction

    function automatic logic is_zero(input logic [hwt_pkg::DATA_W-1:0] v);
        is_zero = (v == hwt_pkg::COUNT_ZERO);
    endfunction

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [hwt_pkg::DATA_W-1:0] preload_r;
    logic [hwt_pkg::DATA_W-1:0] control_r;
    logic [hwt_pkg::DATA_W-1:0] count_r;
    logic [hwt_pkg::DATA_W-1:0] count_nxt;
    hwt_pkg::hwt_cnt_state_e state_r;
    hwt_pkg::hwt_cnt_state_e state_nxt;
    logic [hwt_pkg::DATA_W-1:0] rdata_r;
    logic rvalid_r;
    logic wake_r;
    logic wake_nxt;
    logic load_pend_r;
    logic lp_ack_r;
    logic wr_preload;
    logic wr_control;
    logic rd_any;
    logic load_start;
    logic load_stop;
    logic tick;
    logic run;
    logic res_long;

    // ==========================================================
    // Register write decode
    // ==========================================================
    // A write is taken in the very cycle it is presented; no wait is inserted.
    assign wr_preload = addr_hit(bus_req, hwt_pkg::OFS_PRELOAD) && bus_req.wr;
    assign wr_control = addr_hit(bus_req, hwt_pkg::OFS_CONTROL) && bus_req.wr;
    assign rd_any = bus_req.sel && bus_req.rd;

    assign load_start = wr_preload && !is_zero(bus_req.wdata);
    assign load_stop = wr_preload && is_zero(bus_req.wdata);

    assign res_long = control_r[hwt_pkg::CTRL_RES_BIT];

    // ==========================================================
    // Preload register
    // ==========================================================
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            preload_r <= hwt_pkg::PRELOAD_RST;
        end else if (wr_preload) begin
            preload_r <= bus_req.wdata;
        end
    end

    // ==========================================================
    // Control register
    // ==========================================================
    // Only the resolution bit is stored; the other bits read as zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            control_r <= hwt_pkg::CONTROL_RST;
        end else if (wr_control) begin
            control_r <= hwt_pkg::CONTROL_RST;
            control_r[hwt_pkg::CTRL_RES_BIT] <= bus_req.wdata[hwt_pkg::CTRL_RES_BIT];
        end
    end

    // ==========================================================
    // Low power handshake
    // ==========================================================
    // While the power unit holds the block in low power the prescaler and
    // counter are frozen, but registers stay reachable so a preload can still
    // be written. The acknowledge follows the request by one cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lp_ack_r <= 1'b0;
        end else begin
            lp_ack_r <= lp_req;
        end
    end

    assign lp_ack = lp_ack_r;

    // The sleep enable has no path into the block; counting goes on regardless.
    assign run = (state_r == hwt_pkg::CNT_RUN) && !lp_req;

    // ==========================================================
    // Tick generation
    // ==========================================================
    // Only the slow reference paces the counter, so stopping the fast
    // oscillator elsewhere on the chip does not disturb the timing.
    hwt_tick_gen u_tick (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .slow_ref_clk(slow_ref_clk),
        .res_long(res_long),
        .restart(load_start),
        .run(run),
        .tick(tick)
    );

    // ==========================================================
    // Down counter
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        wake_nxt = 1'b0;
        unique case (state_r)
            hwt_pkg::CNT_IDLE: begin
                state_nxt = hwt_pkg::CNT_IDLE;
            end
            hwt_pkg::CNT_RUN: begin
                if (tick) begin
                    count_nxt = count_r - hwt_pkg::COUNT_ONE;
                    if (count_r == hwt_pkg::COUNT_ONE) begin
                        state_nxt = hwt_pkg::CNT_DONE;
                        wake_nxt = 1'b1;
                    end
                end
            end
            hwt_pkg::CNT_DONE: begin
                count_nxt = hwt_pkg::COUNT_ZERO;
            end
            default: begin
                state_nxt = hwt_pkg::CNT_IDLE;
                count_nxt = hwt_pkg::COUNT_ZERO;
            end
        endcase
        // A new preload overrides any step in the same cycle.
        if (load_start) begin
            state_nxt = hwt_pkg::CNT_RUN;
            count_nxt = bus_req.wdata;
            wake_nxt = 1'b0;
        end else if (load_stop) begin
            state_nxt = hwt_pkg::CNT_IDLE;
            count_nxt = hwt_pkg::COUNT_ZERO;
            wake_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= hwt_pkg::CNT_IDLE;
            count_r <= hwt_pkg::COUNT_RST;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

    // ==========================================================
    // Wake event
    // ==========================================================
    // One-cycle pulse for the wake source bit of the aggregator, which keeps
    // it sticky; the pulse is never repeated while the count sits at zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wake_nxt;
        end
    end

    assign wake_event_out = wake_r;

    // ==========================================================
    // Register read
    // ==========================================================
    function automatic logic [hwt_pkg::DATA_W-1:0] read_mux(
        input logic [hwt_pkg::ADDR_W-1:0] a,
        input logic [hwt_pkg::DATA_W-1:0] pre,
        input logic [hwt_pkg::DATA_W-1:0] ctl,
        input logic [hwt_pkg::DATA_W-1:0] cnt
    );
        unique case (a)
            hwt_pkg::OFS_PRELOAD: read_mux = pre;
            hwt_pkg::OFS_CONTROL: read_mux = ctl;
            hwt_pkg::OFS_COUNT: read_mux = cnt;
            default: read_mux = hwt_pkg::RDATA_NONE;
        endcase
    endfunction

    // Read data is held until the next read so software may sample it late.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= hwt_pkg::RDATA_NONE;
        end else if (rd_any) begin
            rdata_r <= read_mux(bus_req.addr, preload_r, control_r, count_r);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= rd_any;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

    // ==========================================================
    // Clock request
    // ==========================================================
    // The request covers the access cycle and the one cycle after it in
    // which a write lands in the counter or a read answer is returned.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            load_pend_r <= 1'b0;
        end else begin
            load_pend_r <= bus_req.sel && (bus_req.wr || bus_req.rd);
        end
    end

    assign clk_req = (bus_req.sel && (bus_req.wr || bus_req.rd)) || load_pend_r;

endmodule // hwt_wake_timer

//--- tb/hwt_wake_timer_props.sv
// Purpose: Port-level checks for the wake timer top.
// Assumes: One clock domain; resetn is active low.
// Notes:   Bound to every instance of the timer top.
`timescale 1ns/1ps
module hwt_wake_timer_props (
    input wire logic clk_sys,
    input wire logic resetn,
    input hwt_pkg::hwt_bus_req_s bus_req,
    input wire logic [hwt_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic slow_ref_clk,
    input wire logic lp_req,
    input wire logic lp_ack,
    input wire logic sleep_en,
    input wire logic clk_req,
    input wire logic wake_event_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic rd_go, wr_go, zero_wr;
    assign rd_go = bus_req.sel && bus_req.rd;
    assign wr_go = bus_req.sel && bus_req.wr;
    assign zero_wr = wr_go && bus_req.addr == hwt_pkg::OFS_PRELOAD && bus_req.wdata == 16'h0000;
    // ==========================================================
    // Properties
    // ==========================================================
    property p_rd_ans; rd_go |=> reg_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_no_spur; !rd_go |=> !reg_rvalid; endproperty
    a_no_spur: assert property (p_no_spur) else $error("spurious read valid");
    property p_rd_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmap; rd_go && bus_req.addr == 4'hC |=> reg_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_creq_on; rd_go || wr_go |-> clk_req ##1 clk_req; endproperty
    a_creq_on: assert property (p_creq_on) else $error("clock request missing");
    property p_creq_off; clk_req |-> rd_go || wr_go || $past(rd_go || wr_go); endproperty
    a_creq_off: assert property (p_creq_off) else $error("clock request idle");
    property p_lp_ack; $past(resetn) |-> lp_ack == $past(lp_req); endproperty
    a_lp_ack: assert property (p_lp_ack) else $error("low power ack wrong");
    property p_lp_quiet; lp_req [*6] |-> !wake_event_out; endproperty
    a_lp_quiet: assert property (p_lp_quiet) else $error("wake in low power");
    property p_wake_one; wake_event_out |=> !wake_event_out; endproperty
    a_wake_one: assert property (p_wake_one) else $error("wake pulse too long");
    property p_zero_quiet; zero_wr |-> ##2 !wake_event_out [*8]; endproperty
    a_zero_quiet: assert property (p_zero_quiet) else $error("wake after disable");
    c_wake: cover property (wake_event_out);
    c_read: cover property (rd_go ##1 reg_rvalid);
    c_lp: cover property (lp_req ##1 lp_ack);
endmodule // hwt_wake_timer_props

bind hwt_wake_timer hwt_wake_timer_props u_hwt_wake_timer_props (.clk_sys(clk_sys),
    .resetn(resetn), .bus_req(bus_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .slow_ref_clk(slow_ref_clk), .lp_req(lp_req), .lp_ack(lp_ack), .sleep_en(sleep_en),
    .clk_req(clk_req), .wake_event_out(wake_event_out));

//--- tb/hwt_aggr_model.sv
// Purpose: Wake source bit of the interrupt aggregator.
// Assumes: Wake input is a one-cycle pulse on clk_sys.
// Notes:   Cleared by software through src_clr.
`timescale 1ns/1ps
module hwt_aggr_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic wake_event_out,
    input wire logic src_clr,
    output logic wake_src_r
);
    // The bit is sticky so a single-cycle pulse is never lost.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wake_src_r <= 1'b0;
        end else if (wake_event_out) begin
            wake_src_r <= 1'b1;
        end else if (src_clr) begin
            wake_src_r <= 1'b0;
        end
    end
endmodule // hwt_aggr_model

//--- tb/hwt_wake_timer_tb_top.sv
// Purpose: Self-checking bench for the wake timer.
// Assumes: Slow clock is driven fast, eight system cycles a period.
// Notes:   Long mode run takes about 33000 cycles.
`timescale 1ns/1ps
module hwt_wake_timer_tb_top;
    logic clk_sys, resetn, slow_ref_clk, lp_req, lp_ack, sleep_en, clk_req;
    logic wake_event_out, reg_rvalid, src_clr, wake_src_r;
    logic [15:0] reg_rdata;
    hwt_pkg::hwt_bus_req_s bus_req;
    int error_cnt, compares, cyc, wake_cnt;
    hwt_wake_timer u_hwt_wake_timer (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .slow_ref_clk(slow_ref_clk),
        .lp_req(lp_req), .lp_ack(lp_ack), .sleep_en(sleep_en), .clk_req(clk_req),
        .wake_event_out(wake_event_out));
    hwt_aggr_model u_hwt_aggr_model (.clk_sys(clk_sys), .resetn(resetn),
        .wake_event_out(wake_event_out), .src_clr(src_clr), .wake_src_r(wake_src_r));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (wake_event_out === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
        if (cyc == 80000) begin
            error_cnt = error_cnt + 1;
            results();
        end
    end
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic results();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        bus_req <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk(reg_rdata, exp);
    endtask
    task automatic slow_edges(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_sys);
            slow_ref_clk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            slow_ref_clk <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_defaults();
        rd_chk(hwt_pkg::OFS_PRELOAD, 16'h0000);
        rd_chk(hwt_pkg::OFS_CONTROL, 16'h0000);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0000);
        rd_chk(4'hC, 16'h0000);
        $display("defaults test done");
    endtask
    task automatic t_ctrl();
        bus_wr(hwt_pkg::OFS_CONTROL, 16'hFFFF);
        rd_chk(hwt_pkg::OFS_CONTROL, 16'h0001);
        bus_wr(hwt_pkg::OFS_COUNT, 16'h1234);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0000);
        bus_wr(hwt_pkg::OFS_CONTROL, 16'h0000);
        #1;
        chk({15'h0000, clk_req}, 16'h0001);
        @(posedge clk_sys);
        #1;
        chk({15'h0000, clk_req}, 16'h0000);
        $display("control test done");
    endtask
    task automatic t_short();
        int w0;
        w0 = wake_cnt;
        sleep_en <= 1'b1;
        bus_wr(hwt_pkg::OFS_PRELOAD, 16'h0005);
        slow_edges(3);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0002);
        chk(16'(wake_cnt - w0), 16'h0000);
        slow_edges(2);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0000);
        chk(16'(wake_cnt - w0), 16'h0001);
        chk({15'h0000, wake_src_r}, 16'h0001);
        slow_edges(3);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0000);
        chk(16'(wake_cnt - w0), 16'h0001);
        src_clr <= 1'b1;
        @(posedge clk_sys);
        src_clr <= 1'b0;
        sleep_en <= 1'b0;
        $display("short tick test done");
    endtask
    task automatic t_reload();
        int w0;
        w0 = wake_cnt;
        bus_wr(hwt_pkg::OFS_PRELOAD, 16'h0003);
        bus_wr(hwt_pkg::OFS_PRELOAD, 16'h0007);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0007);
        slow_edges(1);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0006);
        bus_wr(hwt_pkg::OFS_PRELOAD, 16'h0000);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0000);
        slow_edges(8);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0000);
        chk(16'(wake_cnt - w0), 16'h0000);
        $display("reload test done");
    endtask
    task automatic t_lp();
        bus_wr(hwt_pkg::OFS_PRELOAD, 16'h0004);
        lp_req <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({15'h0000, lp_ack}, 16'h0001);
        slow_edges(3);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0004);
        @(posedge clk_sys);
        lp_req <= 1'b0;
        slow_edges(1);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0003);
        chk({15'h0000, lp_ack}, 16'h0000);
        $display("low power test done");
    endtask
    task automatic t_long();
        bus_wr(hwt_pkg::OFS_CONTROL, 16'h0001);
        bus_wr(hwt_pkg::OFS_PRELOAD, 16'h0002);
        slow_edges(4095);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0002);
        slow_edges(1);
        rd_chk(hwt_pkg::OFS_COUNT, 16'h0001);
        do_reset();
        t_defaults();
        $display("long tick and reset test done");
    endtask
    initial begin
        resetn = 1'b0;
        slow_ref_clk = 1'b0;
        lp_req = 1'b0;
        sleep_en = 1'b0;
        src_clr = 1'b0;
        bus_req = '0;
        do_reset();
        t_defaults();
        t_ctrl();
        t_short();
        t_reload();
        t_lp();
        t_long();
        results();
    end
endmodule // hwt_wake_timer_tb_top
